// [hdl/gst_pkg.sv]
// Constants, configuration carrier and states of the gated 16-bit timer.
// Assumes one 125 MHz clock domain and an active-low async reset.
package gst_pkg;

  localparam int CNT_W       = 16;
  localparam int PS_W        = 3;
  localparam int SYNC_STAGES = 2;

  localparam logic [1:0] SRC_SYS  = 2'h0;
  localparam logic [1:0] SRC_PIN  = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;

  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV2 = 2'h1;
  localparam logic [1:0] PS_DIV4 = 2'h2;
  localparam logic [1:0] PS_DIV8 = 2'h3;

  localparam logic [PS_W-1:0] PS_MASK1 = 3'h0;
  localparam logic [PS_W-1:0] PS_MASK2 = 3'h1;
  localparam logic [PS_W-1:0] PS_MASK4 = 3'h3;
  localparam logic [PS_W-1:0] PS_MASK8 = 3'h7;

  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [PS_W-1:0]  PS_RST   = 3'h0;
  localparam logic [PS_W-1:0]  PS_ONE   = 3'h1;

  // Control bits gathered from the timer and gate control registers
  typedef struct packed {
    logic       timer_on;
    logic [1:0] clk_src;
    logic [1:0] prescale_select;
    logic       crystal_osc_enable;
    logic       sync_disable_bit;
    logic       gate_enable_bit;
    logic       gate_polarity_bit;
    logic       gate_single_pulse_bit;
    logic       gate_src_sel;
  } gst_cfg_t;

  typedef enum logic [1:0] {
    GP_IDLE  = 2'b00,
    GP_ARMED = 2'b01,
    GP_RUN   = 2'b10
  } gst_gp_t;

endpackage

// [hdl/gst_sync.sv]
// Two-or-more stage level synchroniser, one chain per bit.
// Assumes inputs are asynchronous to clk; only the last stage is read.
module gst_sync
  import gst_pkg::*;
#(
  parameter int W      = 3,
  parameter int STAGES = SYNC_STAGES
) (
  input  wire logic         clk,    // System clock
  input  wire logic         arst_n, // Async reset, active low
  input  wire logic [W-1:0] d,      // Asynchronous levels
  output logic      [W-1:0] q       // Synchronised levels
);

  if (STAGES < 2 || W < 1) begin : g_bad_cfg
    $error("gst_sync needs W >= 1 and STAGES >= 2");
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic [STAGES-1:0] chain_q;
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          chain_q <= '0;
        end else begin
          chain_q <= {chain_q[STAGES-2:0], d[i]};
        end
      end
      assign q[i] = chain_q[STAGES-1];
    end
  endgenerate

endmodule

// [hdl/gst_timer.sv]
// Gated 16-bit up-counter with prescaler, crystal amplifier and gate logic.
// Assumes pins are asynchronous, all other inputs are on clk.
// What this block does
// (RL1) Crystal amplifier runs only when enabled
// (RL2) Enabled crystal amplifier keeps running in sleep
// (RL3) Software presets FC00h, waits overflow to settle
// (RL4) Async mode uses earlier, unaligned external edge
// (RL5) Async external counting continues during sleep
// (RL6) Mode switch may drop or add one count
// (RL7) Counter bytes always read a stable value
// (RL8) Software stops timer before writing bytes; only t_ovf does, the other bench writes hit a running timer
// (RL9) Counter runs freely or under gate control
// (RL10) Gate enable bit makes counting follow gate
// (RL11) Polarity bit selects active gate level
// (RL12) Permitted: increment on selected clock rising edge
// (RL13) Blocked: count holds unchanged
// (RL14) Single pulse: start on rise, done on fall
// (RL15) Prescale 1/2/4/8; byte write clears prescaler
// (RL16) Wrap to zero sets overflow flag
module gst_timer
  import gst_pkg::*;
(
  input  wire logic       clk,                 // 125 MHz system clock
  input  wire logic       arst_n,              // Async reset, active low
  input  wire gst_cfg_t   cfg,                 // Control bits
  input  wire logic       sleep,               // Processor in sleep
  input  wire logic       external_clock_pin,  // External count pin
  input  wire logic       crystal_osc_input,   // Crystal amplifier input
  input  wire logic       gate_input,          // Gate pin
  input  wire logic       gate_alt_input,      // On-chip gate source
  input  wire logic       wr_low,              // Write low counter byte
  input  wire logic       wr_high,             // Write high counter byte
  input  wire logic [7:0] wr_data,             // Byte write data
  input  wire logic       gate_go_set,         // Arm single pulse
  input  wire logic       ovf_clear,           // Clear overflow flag
  input  wire logic       gate_flag_clear,     // Clear gate event flag
  output logic            crystal_osc_output,  // Crystal amplifier output
  output logic [7:0]      counter_low_byte,    // Count bits 7..0
  output logic [7:0]      counter_high_byte,   // Count bits 15..8
  output logic            timer_overflow_flag, // Sticky wrap flag
  output logic            gate_event_flag,     // Sticky pulse done flag
  output logic            gate_pulse_go_done,  // Single pulse armed/busy
  output logic            gate_current_value   // Active gate level
);

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge stages

  logic [2:0] pin_s;
  logic [1:0] lvl_d1_q;
  logic [1:0] lvl_d2_q;
  logic [1:0] lvl_now;
  logic [1:0] edge_async;
  logic [1:0] edge_sync;

  gst_sync #(.W(3), .STAGES(SYNC_STAGES)) gst_sync_inst (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({gate_input, crystal_osc_input, external_clock_pin}),
    .q      (pin_s)
  );

  // Bit 0 external pin, bit 1 crystal level (only when enabled)
  assign lvl_now = {pin_s[1] & cfg.crystal_osc_enable, pin_s[0]};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_d1_q <= 2'h0;
      lvl_d2_q <= 2'h0;
    end else begin
      lvl_d1_q <= lvl_now;
      lvl_d2_q <= lvl_d1_q;
    end
  end

  assign edge_async = lvl_now & ~lvl_d1_q;
  assign edge_sync  = lvl_d1_q & ~lvl_d2_q;

  //////////////////////////////////////////////////////////////////////////
  // Crystal amplifier

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crystal_osc_output <= 1'b0;
    end else begin
      // No sleep term: the amplifier runs through sleep
      crystal_osc_output <= cfg.crystal_osc_enable & ~pin_s[1]; // RL1 RL2
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock source selection

  logic       src_edge;
  logic [1:0] ext_edge;

  // Sync mode takes the aligned edge one stage later than async mode
  assign ext_edge = cfg.sync_disable_bit ? edge_async         // RL4 RL6
                                         : edge_sync & {2{~sleep}}; // RL5

  always_comb begin
    case (cfg.clk_src)
      SRC_SYS:  src_edge = ~sleep;
      SRC_PIN:  src_edge = ext_edge[0];   // RL5
      SRC_XTAL: src_edge = ext_edge[1];   // RL12
      default:  src_edge = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Gate and single-pulse sequencing

  logic    gate_raw;
  logic    gate_act;
  logic    gate_rise;
  logic    gate_fall;
  logic    count_ok;
  gst_gp_t gp_q;

  assign gate_raw  = cfg.gate_src_sel ? gate_alt_input : pin_s[2]; // RL9
  assign gate_act  = cfg.gate_polarity_bit ? gate_raw : ~gate_raw; // RL11
  assign gate_rise = gate_act & ~gate_current_value;
  assign gate_fall = ~gate_act & gate_current_value;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_current_value <= 1'b0;
    end else begin
      gate_current_value <= gate_act;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gp_q <= GP_IDLE;
    end else if (!(cfg.gate_enable_bit && cfg.gate_single_pulse_bit)) begin
      gp_q <= GP_IDLE;
    end else begin
      case (gp_q)
        GP_IDLE:  if (gate_go_set) gp_q <= GP_ARMED;
        GP_ARMED: if (gate_rise) gp_q <= GP_RUN;   // RL14
        GP_RUN:   if (gate_fall) gp_q <= GP_IDLE;  // RL14
        default:  gp_q <= GP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_pulse_go_done <= 1'b0;
    end else if (!(cfg.gate_enable_bit && cfg.gate_single_pulse_bit)) begin
      gate_pulse_go_done <= 1'b0;
    end else if (gp_q == GP_RUN && gate_fall) begin
      gate_pulse_go_done <= 1'b0;                   // RL14
    end else if (gp_q == GP_IDLE && gate_go_set) begin
      gate_pulse_go_done <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_event_flag <= 1'b0;
    end else if (gp_q == GP_RUN && gate_fall) begin
      gate_event_flag <= 1'b1;                      // RL14
    end else if (gate_flag_clear) begin
      gate_event_flag <= 1'b0;
    end
  end

  always_comb begin
    if (!cfg.timer_on) begin
      count_ok = 1'b0;
    end else if (!cfg.gate_enable_bit) begin
      count_ok = 1'b1;                              // RL9
    end else if (cfg.gate_single_pulse_bit) begin
      count_ok = (gp_q == GP_RUN) && gate_act;      // RL14
    end else begin
      count_ok = gate_act;                          // RL10 RL13
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Prescaler and counter

  logic [PS_W-1:0]  ps_q;
  logic [PS_W-1:0]  ps_mask;
  logic [CNT_W-1:0] cnt_q;
  logic             tick;
  logic             inc;
  logic             wr_any;

  always_comb begin
    case (cfg.prescale_select)
      PS_DIV1: ps_mask = PS_MASK1;
      PS_DIV2: ps_mask = PS_MASK2;
      PS_DIV4: ps_mask = PS_MASK4;
      PS_DIV8: ps_mask = PS_MASK8;
      default: ps_mask = PS_MASK1;
    endcase
  end

  assign wr_any = wr_low | wr_high;
  assign tick   = src_edge & count_ok;                         // RL12 RL13
  assign inc    = tick & ((ps_q & ps_mask) == ps_mask);        // RL15

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ps_q <= PS_RST;
    end else if (wr_any) begin
      ps_q <= PS_RST;                                          // RL15
    end else if (tick) begin
      ps_q <= ps_q + PS_ONE;
    end
  end

  // A byte write beats a colliding increment
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= CNT_RST;
    end else if (wr_any) begin
      if (wr_low) cnt_q[7:0] <= wr_data;
      if (wr_high) cnt_q[15:8] <= wr_data;
    end else if (inc) begin
      cnt_q <= cnt_q + CNT_ONE;                                // RL12
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_overflow_flag <= 1'b0;
    end else if (inc && !wr_any && cnt_q == CNT_MAX) begin
      timer_overflow_flag <= 1'b1;                             // RL16
    end else if (ovf_clear) begin
      timer_overflow_flag <= 1'b0;
    end
  end

  // Bytes come from the clk-domain count, never from a pin edge
  assign counter_low_byte  = cnt_q[7:0];                       // RL7
  assign counter_high_byte = cnt_q[15:8];                      // RL7

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_osc_off;
    !cfg.crystal_osc_enable |=> !crystal_osc_output;
  endproperty
  a_osc_off: assert property (p_osc_off) // RL1
    else $error("crystal amplifier drives while disabled");

  property p_osc_sleep;
    cfg.crystal_osc_enable && sleep |=> crystal_osc_output == !$past(pin_s[1]);
  endproperty
  a_osc_sleep: assert property (p_osc_sleep) // RL2
    else $error("crystal amplifier stopped in sleep");

  property p_async_pin;
    cfg.sync_disable_bit && cfg.clk_src == SRC_PIN && ps_mask == PS_MASK1
      && count_ok && edge_async[0] && !wr_any
      |=> cnt_q == $past(cnt_q) + CNT_ONE;
  endproperty
  a_async_pin: assert property (p_async_pin) // RL4
    else $error("async external edge did not count");

  property p_sleep_sync_hold;
    sleep && !cfg.sync_disable_bit && cfg.clk_src != SRC_SYS && !wr_any
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_sleep_sync_hold: assert property (p_sleep_sync_hold) // RL5
    else $error("synchronised counting continued in sleep");

  property p_free_run;
    cfg.timer_on && !cfg.gate_enable_bit && cfg.clk_src == SRC_SYS
      && ps_mask == PS_MASK1 && !sleep && !wr_any
      |=> cnt_q == $past(cnt_q) + CNT_ONE;
  endproperty
  a_free_run: assert property (p_free_run) // RL9
    else $error("free-running counter missed a count");

  property p_gate_hold;
    cfg.gate_enable_bit && !gate_act && !wr_any |=> $stable(cnt_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold) // RL13
    else $error("counter moved while gate blocked");

  property p_gate_level;
    1'b1 |=> gate_current_value ==
      ($past(cfg.gate_polarity_bit) ? $past(gate_raw) : !$past(gate_raw));
  endproperty
  a_gate_level: assert property (p_gate_level) // RL11
    else $error("gate level ignores polarity");

  property p_pulse_done;
    gp_q == GP_RUN && gate_fall && cfg.gate_enable_bit
      && cfg.gate_single_pulse_bit
      |=> !gate_pulse_go_done && gate_event_flag && gp_q == GP_IDLE;
  endproperty
  a_pulse_done: assert property (p_pulse_done) // RL14
    else $error("single pulse did not finish on gate fall");

  property p_pulse_armed_hold;
    cfg.gate_enable_bit && cfg.gate_single_pulse_bit && gp_q == GP_ARMED
      && !wr_any |=> $stable(cnt_q);
  endproperty
  a_pulse_armed_hold: assert property (p_pulse_armed_hold) // RL14
    else $error("counting before gate rise in single pulse");

  property p_write_clears_ps;
    wr_low && !wr_high |=> ps_q == PS_RST && cnt_q[7:0] == $past(wr_data);
  endproperty
  a_write_clears_ps: assert property (p_write_clears_ps) // RL15
    else $error("low byte write did not load or clear prescaler");

  property p_div8;
    tick && !inc && !wr_any |=> cnt_q == $past(cnt_q);
  endproperty
  a_div8: assert property (p_div8) // RL15
    else $error("counter advanced on a prescaled-out tick");

  property p_wrap;
    inc && !wr_any && cnt_q == CNT_MAX |=> cnt_q == CNT_RST
      && timer_overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) // RL16
    else $error("wrap did not set overflow flag");

  c_wrap: cover property (inc && cnt_q == CNT_MAX);
  c_pulse: cover property (gp_q == GP_RUN && gate_fall);
  c_async_sleep: cover property (sleep && cfg.sync_disable_bit && inc);

endmodule

// [bench/gst_timer_bench.sv]
// Self-checking bench for the gated 16-bit timer.
// Assumes gst_pkg and gst_timer are compiled first; the bench drives every
// input at the falling edge of the 125 MHz clock.
module gst_timer_bench import gst_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

  ////////////////////////////////////////////////////////////////////////////
  logic        clk;
  logic        arst_n;
  gst_cfg_t    cfg;
  logic        sleep;
  logic        external_clock_pin;
  logic        crystal_osc_input;
  logic        gate_input;
  logic        gate_alt_input;
  logic        wr_low;
  logic        wr_high;
  logic [7:0]  wr_data;
  logic        gate_go_set;
  logic        ovf_clear;
  logic        gate_flag_clear;
  logic        crystal_osc_output;
  logic [7:0]  counter_low_byte;
  logic [7:0]  counter_high_byte;
  logic        timer_overflow_flag;
  logic        gate_event_flag;
  logic        gate_pulse_go_done;
  logic        gate_current_value;
  logic [15:0] cnt;
  int          n_fail;
  int          n_tests;

  assign cnt = {counter_high_byte, counter_low_byte};

  gst_timer gst_timer_inst (
    .clk                 (clk),
    .arst_n              (arst_n),
    .cfg                 (cfg),
    .sleep               (sleep),
    .external_clock_pin  (external_clock_pin),
    .crystal_osc_input   (crystal_osc_input),
    .gate_input          (gate_input),
    .gate_alt_input      (gate_alt_input),
    .wr_low              (wr_low),
    .wr_high             (wr_high),
    .wr_data             (wr_data),
    .gate_go_set         (gate_go_set),
    .ovf_clear           (ovf_clear),
    .gate_flag_clear     (gate_flag_clear),
    .crystal_osc_output  (crystal_osc_output),
    .counter_low_byte    (counter_low_byte),
    .counter_high_byte   (counter_high_byte),
    .timer_overflow_flag (timer_overflow_flag),
    .gate_event_flag     (gate_event_flag),
    .gate_pulse_go_done  (gate_pulse_go_done),
    .gate_current_value  (gate_current_value)
  );

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One-cycle byte write; returns at the falling edge after the write edge
  task automatic wr(input logic hs, input logic ls, input logic [7:0] d);
    wr_high = hs;
    wr_low  = ls;
    wr_data = d;
    step(1);
    wr_high = 1'b0;
    wr_low  = 1'b0;
  endtask

  task automatic final_report;
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK(cnt, 16'h0000)
    `CHK(timer_overflow_flag, 1'b0)
    `CHK(gate_pulse_go_done, 1'b0)
  endtask

  // Every divide ratio; the write also clears a half-filled prescaler
  task automatic t_prescale;
    cfg.clk_src  = SRC_SYS;
    cfg.timer_on = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cfg.prescale_select = i[1:0];
      wr(1'b1, 1'b1, 8'h00);
      step(16);
      `CHK(cnt, 16'(16 >> i))
      step(i + 1);
    end
  endtask

  task automatic t_ovf;
    cfg.timer_on = 1'b0;
    cfg.prescale_select = PS_DIV1;
    ovf_clear = 1'b1;
    step(1);
    ovf_clear = 1'b0;
    wr(1'b1, 1'b0, 8'hfc);
    step(1);
    wr(1'b0, 1'b1, 8'h00);
    `CHK(cnt, 16'hfc00)
    cfg.timer_on = 1'b1;
    step(1023);
    `CHK(cnt, 16'hffff)
    `CHK(timer_overflow_flag, 1'b0)
    step(1);
    `CHK(cnt, 16'h0000)
    `CHK(timer_overflow_flag, 1'b1)
    ovf_clear = 1'b1;
    step(1);
    ovf_clear = 1'b0;
    `CHK(timer_overflow_flag, 1'b0)
  endtask

  // Polarity by level table, then gate ignored when gate mode is off
  task automatic t_gate;
    logic lvl;
    logic pol;
    cfg.gate_src_sel = 1'b1;
    for (int k = 0; k < 5; k++) begin
      pol = (k == 4) ? 1'b1 : k[1];
      lvl = (k == 4) ? 1'b0 : k[0];
      cfg.gate_enable_bit   = (k < 4);
      cfg.gate_polarity_bit = pol;
      gate_alt_input = lvl;
      step(4);
      wr(1'b1, 1'b1, 8'h00);
      step(8);
      if (k < 4) `CHK(gate_current_value, pol == lvl)
      `CHK(cnt, (pol == lvl || k == 4) ? 16'h0008 : 16'h0000)
    end
  endtask

  task automatic t_pulse;
    logic [15:0] held;
    cfg.gate_enable_bit       = 1'b1;
    cfg.gate_single_pulse_bit = 1'b1;
    cfg.gate_polarity_bit     = 1'b1;
    cfg.gate_src_sel          = 1'b0;
    gate_input = 1'b0;
    step(4);
    wr(1'b1, 1'b1, 8'h00);
    gate_go_set = 1'b1;
    step(1);
    gate_go_set = 1'b0;
    step(5);
    `CHK(gate_pulse_go_done, 1'b1)
    `CHK(cnt, 16'h0000)
    gate_input = 1'b1;
    step(20);
    `CHK(gate_current_value, 1'b1)
    `CHK(cnt, 16'h0011)
    gate_input = 1'b0;
    step(8);
    `CHK(gate_pulse_go_done, 1'b0)
    `CHK(gate_event_flag, 1'b1)
    `CHK(cnt, 16'h0013)
    held = cnt;
    gate_input = 1'b1;
    step(8);
    `CHK(cnt, held)
    gate_input = 1'b0;
    gate_flag_clear = 1'b1;
    step(1);
    gate_flag_clear = 1'b0;
    `CHK(gate_event_flag, 1'b0)
    cfg.gate_single_pulse_bit = 1'b0;
    cfg.gate_enable_bit       = 1'b0;
  endtask

  // Pulses n rising edges on the selected pin and returns the count seen
  task automatic ext(input logic [1:0] src, input logic asy, input logic slp,
                     input int n, output logic [15:0] got);
    cfg.clk_src          = src;
    cfg.sync_disable_bit = asy;
    sleep = slp;
    step(4);
    wr(1'b1, 1'b1, 8'h00);
    repeat (n) begin
      if (src == SRC_PIN) external_clock_pin = 1'b1;
      else crystal_osc_input = 1'b1;
      step(4);
      external_clock_pin = 1'b0;
      crystal_osc_input  = 1'b0;
      step(4);
    end
    got = cnt;
  endtask

  task automatic t_ext;
    logic [15:0] got;
    ext(SRC_PIN, 1'b1, 1'b1, 6, got);
    `CHK(got, 16'h0006)
    ext(SRC_PIN, 1'b0, 1'b1, 6, got);
    `CHK(got, 16'h0000)
    ext(SRC_PIN, 1'b0, 1'b0, 6, got);
    `CHK(got, 16'h0006)
    cfg.crystal_osc_enable = 1'b0;
    ext(SRC_XTAL, 1'b1, 1'b0, 5, got);
    `CHK(got, 16'h0000)
    `CHK(crystal_osc_output, 1'b0)
    cfg.crystal_osc_enable = 1'b1;
    ext(SRC_XTAL, 1'b1, 1'b1, 5, got);
    `CHK(got, 16'h0005)
    `CHK(crystal_osc_output, 1'b1)
    crystal_osc_input = 1'b1;
    step(4);
    `CHK(crystal_osc_output, 1'b0)
    // Unused source code: nothing may count
    ext(2'h3, 1'b1, 1'b0, 3, got);
    `CHK(got, 16'h0000)
    sleep = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    cfg = '0;
    sleep = 1'b0;
    external_clock_pin = 1'b0;
    crystal_osc_input = 1'b0;
    gate_input = 1'b0;
    gate_alt_input = 1'b0;
    wr_low = 1'b0;
    wr_high = 1'b0;
    wr_data = 8'h00;
    gate_go_set = 1'b0;
    ovf_clear = 1'b0;
    gate_flag_clear = 1'b0;
    n_fail = 0;
    n_tests = 0;
    step(2);
    arst_n = 1'b1;
    step(1);
    t_reset();
    t_prescale();
    t_ovf();
    t_gate();
    t_pulse();
    t_ext();
    final_report();
  end

  // Whole run is about 1500 cycles; cut off well beyond that
  initial begin
    #200000;
    n_fail++;
    final_report();
  end

endmodule
